// *** core/iolr_mux.sv ***
`timescale 1ns/1ps
module iolr_mux
(
  // clock and reset
  input wire logic CORE_CLK,
  input wire logic RST,
  input wire logic POR,
  input wire logic EXT_RESET_HELD,
  // pins
  input wire logic [iolr_pkg::NUM_LINES-1:0] PAD_IN,
  output iolr_pkg::iolr_pad_t PAD,
  // gpio controller
  input wire logic [iolr_pkg::NUM_LINES-1:0] GPIO_OUT,
  input wire logic [iolr_pkg::NUM_LINES-1:0] GPIO_OE,
  input wire logic [iolr_pkg::NUM_LINES-1:0] PULL_WR,
  input wire logic [iolr_pkg::NUM_LINES-1:0] PULL_WDATA,
  output logic [iolr_pkg::NUM_LINES-1:0] LINE_IN,
  // function select of port a line 20
  input wire logic RC_LINE_GPIO,
  input wire logic [2:0] RC_LINE_FUNC,
  input wire logic KEEP_BIT_WR_ZERO,
  input wire logic RC_32K_OSC,
  // test port
  input wire logic TDO_DATA,
  output logic TEST_PORT_EN,
  // two-wire pins
  input wire logic [iolr_pkg::NUM_TW-1:0] TW_SEL_WR,
  input wire logic [iolr_pkg::NUM_TW-1:0] TW_SEL_WDATA,
  input wire logic [iolr_pkg::NUM_TW*6-1:0] TW_LINE_IDX,
  input wire logic [iolr_pkg::NUM_TW-1:0] TW_DRIVE_LOW,
  output logic [iolr_pkg::NUM_TW-1:0] TW_SEL,
  output logic [iolr_pkg::NUM_TW-1:0] TW_IN_FILT,
  // converter inputs
  input wire logic [iolr_pkg::NUM_ADC*6-1:0] ADC_LINE_IDX,
  input wire logic [iolr_pkg::NUM_ADC-1:0] ADC_REQ,
  output logic [iolr_pkg::NUM_ADC-1:0] ADC_ALLOW
);
  import iolr_pkg::*;

  logic [NUM_LINES-1:0] sync1_reg, sync2_reg;
  logic [NUM_LINES-1:0] pull_reg;
  logic tck_s1_reg, tck_s2_reg;
  logic rst_held_s1_reg, rst_held_s2_reg, rst_held_d_reg;
  logic test_en_reg;
  logic rc_on_reg;
  logic [NUM_TW-1:0] tw_sel_reg;
  logic [FILT_LEN-1:0] filt_reg [NUM_TW];
  logic [NUM_TW-1:0] filt_out_reg;
  logic in_reset;
  logic rc_kill;

  function automatic logic [5:0] idx_of(input logic [NUM_TW*6-1:0] v, input int k);
    idx_of = v[k*6 +: 6];
  endfunction

  function automatic logic [5:0] adc_idx(input logic [NUM_ADC*6-1:0] v, input int k);
    adc_idx = v[k*6 +: 6];
  endfunction

  // two flops on every pin before use
  always_ff @(posedge CORE_CLK)
  begin
    sync1_reg <= PAD_IN;
    sync2_reg <= sync1_reg;
    tck_s1_reg <= PAD_IN[LINE_TCK];
    tck_s2_reg <= tck_s1_reg;
    rst_held_s1_reg <= EXT_RESET_HELD;
    rst_held_s2_reg <= rst_held_s1_reg;
    rst_held_d_reg <= rst_held_s2_reg;
  end
  assign LINE_IN = sync2_reg;
  assign in_reset = RST | rst_held_s2_reg;

  // decision taken on the falling edge of the synchronised reset hold
  always_ff @(posedge CORE_CLK)
  begin
    if (RST)
      test_en_reg <= 1'b0;
    else if (rst_held_d_reg && !rst_held_s2_reg)
      test_en_reg <= ~tck_s2_reg;
  end
  assign TEST_PORT_EN = test_en_reg;

  always_ff @(posedge CORE_CLK)
  begin
    if (RST)
      pull_reg <= PULL_RESET;
    else
      pull_reg <= (pull_reg & ~PULL_WR) | (PULL_WDATA & PULL_WR);
  end

  // only power-up rearms the clock output; ordinary resets cannot
  assign rc_kill = RC_LINE_GPIO | (RC_LINE_FUNC != FUNC_F) | KEEP_BIT_WR_ZERO;
  always_ff @(posedge CORE_CLK)
  begin
    if (POR)
      rc_on_reg <= 1'b1;
    else if (rc_kill && !in_reset)
      rc_on_reg <= 1'b0;
  end

  always_ff @(posedge CORE_CLK)
  begin
    if (RST)
      tw_sel_reg <= TW_SEL_RESET;
    else
      tw_sel_reg <= (tw_sel_reg & ~TW_SEL_WR) | (TW_SEL_WDATA & TW_SEL_WR);
  end
  assign TW_SEL = tw_sel_reg;

  // majority-free filter: output follows only a stable run, rejecting spikes
  always_ff @(posedge CORE_CLK)
  begin
    for (int k = 0; k < NUM_TW; k++)
    begin
      if (RST)
      begin
        filt_reg[k] <= '1;
        filt_out_reg[k] <= 1'b1;
      end
      else
      begin
        filt_reg[k] <= {filt_reg[k][FILT_LEN-2:0], sync2_reg[idx_of(TW_LINE_IDX, k)]};
        if (&filt_reg[k])
          filt_out_reg[k] <= 1'b1;
        else if (~|filt_reg[k])
          filt_out_reg[k] <= 1'b0;
      end
    end
  end
  assign TW_IN_FILT = filt_out_reg;

  always_comb
  begin
    PAD.out = GPIO_OUT;
    PAD.oe = GPIO_OE;
    PAD.pull = pull_reg;
    for (int k = 0; k < NUM_TW; k++)
    begin
      if (tw_sel_reg[k])
      begin
        PAD.out[idx_of(TW_LINE_IDX, k)] = 1'b0;
        PAD.oe[idx_of(TW_LINE_IDX, k)] = TW_DRIVE_LOW[k];
      end
    end
    if (rc_on_reg)
    begin
      PAD.out[LINE_RC_OUT] = RC_32K_OSC;
      PAD.oe[LINE_RC_OUT] = 1'b1;
    end
    if (test_en_reg && !in_reset)
    begin
      PAD.pull[LINE_TCK] = 1'b1;
      PAD.pull[LINE_TMS] = 1'b1;
      PAD.pull[LINE_TDI] = 1'b1;
      PAD.oe[LINE_TCK] = 1'b0;
      PAD.oe[LINE_TMS] = 1'b0;
      PAD.oe[LINE_TDI] = 1'b0;
      PAD.out[LINE_TDO] = TDO_DATA;
      PAD.oe[LINE_TDO] = 1'b1;
      PAD.pull[LINE_TDO] = 1'b0;
    end
    if (in_reset)
      PAD.pull[LINE_TCK] = 1'b1;
  end

  always_comb
  begin
    for (int k = 0; k < NUM_ADC; k++)
      ADC_ALLOW[k] = ADC_REQ[k] &
        !(PAD.oe[adc_idx(ADC_LINE_IDX, k)] & PAD.out[adc_idx(ADC_LINE_IDX, k)]);
  end

  property p_tck_pull;
    @(posedge CORE_CLK) RST |-> PAD.pull[LINE_TCK];
  endproperty
  a_tck_pull: assert property (p_tck_pull) else $error("tck pull-up off in reset");

  property p_pull_default;
    @(posedge CORE_CLK) disable iff (RST) $past(RST) && !$past(PULL_WR[1]) |-> !pull_reg[1];
  endproperty
  a_pull_default: assert property (p_pull_default) else $error("pull-up default wrong");

  property p_rc_sticky;
    @(posedge CORE_CLK) disable iff (POR) !rc_on_reg |=> !rc_on_reg;
  endproperty
  a_rc_sticky: assert property (p_rc_sticky) else $error("rc output came back");

  property p_rc_kill;
    @(posedge CORE_CLK) disable iff (POR) rc_kill && !in_reset |=> !rc_on_reg;
  endproperty
  a_rc_kill: assert property (p_rc_kill) else $error("rc output not stopped");

  property p_rc_drive;
    @(posedge CORE_CLK) rc_on_reg |-> PAD.oe[LINE_RC_OUT] && PAD.out[LINE_RC_OUT] == RC_32K_OSC;
  endproperty
  a_rc_drive: assert property (p_rc_drive) else $error("rc clock not driven");

  property p_test_hold;
    @(posedge CORE_CLK) disable iff (RST)
      !(rst_held_d_reg && !rst_held_s2_reg) |=> $stable(test_en_reg);
  endproperty
  a_test_hold: assert property (p_test_hold) else $error("test enable moved");

  property p_test_latch;
    @(posedge CORE_CLK) disable iff (RST)
      rst_held_d_reg && !rst_held_s2_reg |=> test_en_reg == !$past(tck_s2_reg);
  endproperty
  a_test_latch: assert property (p_test_latch) else $error("test enable wrong");

  property p_tdo;
    @(posedge CORE_CLK) test_en_reg && !in_reset |-> PAD.oe[LINE_TDO] && !PAD.pull[LINE_TDO];
  endproperty
  a_tdo: assert property (p_tdo) else $error("tdo not output");

  property p_tw_reset;
    @(posedge CORE_CLK) $past(RST) && !RST |-> &tw_sel_reg;
  endproperty
  a_tw_reset: assert property (p_tw_reset) else $error("two-wire not selected");

  property p_adc;
    @(posedge CORE_CLK) ADC_ALLOW[0] |-> ADC_REQ[0];
  endproperty
  a_adc: assert property (p_adc) else $error("converter allowed without request");

  c_rc_off: cover property (@(posedge CORE_CLK) rc_on_reg ##1 !rc_on_reg);
  c_test_on: cover property (@(posedge CORE_CLK) !test_en_reg ##1 test_en_reg);
  c_tw_free: cover property (@(posedge CORE_CLK) tw_sel_reg[0] ##1 !tw_sel_reg[0]);
endmodule

// *** core/iolr_pkg.sv ***
package iolr_pkg;
  localparam int NUM_LINES = 36;
  localparam int LINE_TCK = 0;
  localparam int LINE_TMS = 1;
  localparam int LINE_TDI = 2;
  localparam int LINE_TDO = 3;
  localparam int LINE_RC_OUT = 20;
  localparam int NUM_TW = 6;
  localparam int NUM_ADC = 8;
  localparam int FILT_LEN = 3;
  localparam logic [NUM_LINES-1:0] PULL_RESET = 36'h000000001;
  localparam logic [2:0] FUNC_F = 3'h5;
  localparam logic [NUM_TW-1:0] TW_SEL_RESET = 6'h3f;
  typedef struct packed {
    logic [NUM_LINES-1:0] out;
    logic [NUM_LINES-1:0] oe;
    logic [NUM_LINES-1:0] pull;
  } iolr_pad_t;
endpackage

// *** bench/iolr_mux_tb.sv ***
`timescale 1ns/1ps
module iolr_mux_tb;
  import iolr_pkg::*;
  logic clk = 1'b0, rst = 1'b1, por = 1'b1, ext = 1'b0, osc = 1'b1, tdo = 1'b1;
  logic rc_gpio = 1'b0, kill = 1'b0, ten;
  logic [NUM_LINES-1:0] pin = '1, gout = '0, goe = '0, pwr = '0, pwd = '0;
  logic [2:0] func = FUNC_F;
  logic [NUM_TW-1:0] tw_wr = '0, tw_wd = '0, tw_low = '0, tw_sel, tw_filt;
  logic [NUM_LINES-1:0] line_in;
  logic [NUM_ADC-1:0] adc_req = '0, adc_allow;
  iolr_pad_t pad;
  int err_count = 0;
  int comparisons = 0;
  iolr_mux iolr_mux_inst
  (
    .CORE_CLK(clk), .RST(rst), .POR(por), .EXT_RESET_HELD(ext), .PAD_IN(pin), .PAD(pad),
    .GPIO_OUT(gout), .GPIO_OE(goe), .PULL_WR(pwr), .PULL_WDATA(pwd), .LINE_IN(line_in),
    .RC_LINE_GPIO(rc_gpio), .RC_LINE_FUNC(func), .KEEP_BIT_WR_ZERO(kill), .RC_32K_OSC(osc),
    .TDO_DATA(tdo), .TEST_PORT_EN(ten), .TW_SEL_WR(tw_wr), .TW_SEL_WDATA(tw_wd),
    .TW_LINE_IDX({6'h11, 6'h07, 6'h05, 6'h1c, 6'h1b, 6'h15}),
    .TW_DRIVE_LOW(tw_low), .TW_SEL(tw_sel), .TW_IN_FILT(tw_filt),
    .ADC_LINE_IDX(48'h00000000000a), .ADC_REQ(adc_req), .ADC_ALLOW(adc_allow)
  );
  initial forever #20 clk = ~clk;
  // fast stand-in for the rc oscillator, toggling every clock, so the pass-through is seen moving
  always @(posedge clk) osc <= ~osc;
  task step(int n);
    repeat (n) @(posedge clk);
  endtask
  task mid;
    @(negedge clk);
  endtask
  task chk(string name, logic [35:0] seen, logic [35:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      err_count++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task final_report;
    $display("comparisons %0d errors %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // test port latched only at external reset release
  task t_test_port;
    step(1);
    ext <= 1'b1;
    pin[LINE_TCK] <= 1'b0;
    step(4);
    mid;
    chk("tck_pull_in_ext", pad.pull[LINE_TCK], 1'b1);
    step(1);
    ext <= 1'b0;
    step(6);
    mid;
    chk("test_en", ten, 1'b1);
    chk("jtag_pulls", pad.pull[2:0], 3'h7);
    chk("tdo_drive", {pad.oe[LINE_TDO], pad.pull[LINE_TDO], pad.out[LINE_TDO]}, 3'h5);
    step(1);
    pin[LINE_TCK] <= 1'b1;
    step(4);
    mid;
    chk("test_en_held", ten, 1'b1);
    step(1);
    ext <= 1'b1;
    step(4);
    ext <= 1'b0;
    step(6);
    goe[LINE_TMS] <= 1'b1;
    gout[LINE_TMS] <= 1'b1;
    step(1);
    mid;
    chk("test_off", ten, 1'b0);
    chk("tms_free", {pad.oe[LINE_TMS], pad.out[LINE_TMS]}, 2'h3);
  endtask
  // per-line pull, analogue block and two-wire pin
  task t_lines;
    step(1);
    pwr[5] <= 1'b1;
    pwd[5] <= 1'b1;
    goe[10] <= 1'b1;
    gout[10] <= 1'b1;
    adc_req[0] <= 1'b1;
    tw_low[0] <= 1'b1;
    step(1);
    pwr[5] <= 1'b0;
    mid;
    chk("pull_5_6", pad.pull[6:5], 2'h1);
    chk("adc_block", adc_allow[0], 1'b0);
    chk("tw_low", {pad.oe[21], pad.out[21]}, 2'h2);
    step(1);
    gout[10] <= 1'b0;
    tw_low[0] <= 1'b0;
    tw_wr[0] <= 1'b1;
    goe[21] <= 1'b1;
    gout[21] <= 1'b1;
    step(1);
    tw_wr[0] <= 1'b0;
    step(1);
    mid;
    chk("adc_allow", adc_allow[0], 1'b1);
    chk("tw_gpio", {tw_sel[0], pad.oe[21], pad.out[21]}, 3'h3);
    step(1);
    pin[21] <= 1'b0;
    step(2);
    pin[21] <= 1'b1;
    step(6);
    mid;
    chk("tw_spike", tw_filt[0], 1'b1);
    step(1);
    pin[21] <= 1'b0;
    step(8);
    mid;
    chk("tw_filt_low", tw_filt[0], 1'b0);
    chk("line_in", line_in, pin);
    step(1);
    pin[21] <= 1'b1;
  endtask
  // rc clock output: kill terms, stickiness, power-up rearm
  task t_rc;
    step(1);
    func <= 3'h2;
    step(1);
    func <= FUNC_F;
    step(3);
    mid;
    chk("rc_func_kill", pad.oe[LINE_RC_OUT], 1'b0);
    step(1);
    por <= 1'b1;
    step(2);
    por <= 1'b0;
    step(1);
    mid;
    chk("rc_rearm", pad.oe[LINE_RC_OUT], 1'b1);
    step(1);
    kill <= 1'b1;
    step(1);
    kill <= 1'b0;
    step(3);
    mid;
    chk("rc_keep_kill", pad.oe[LINE_RC_OUT], 1'b0);
    step(1);
    por <= 1'b1;
    step(2);
    por <= 1'b0;
    rc_gpio <= 1'b1;
    step(3);
    mid;
    chk("rc_gpio_kill", pad.oe[LINE_RC_OUT], 1'b0);
    step(1);
    rst <= 1'b1;
    rc_gpio <= 1'b0;
    step(2);
    mid;
    chk("tck_pull_rst2", pad.pull[LINE_TCK], 1'b1);
    step(1);
    rst <= 1'b0;
    step(2);
    mid;
    chk("rc_after_rst", pad.oe[LINE_RC_OUT], 1'b0);
    chk("pull_rst2", pad.pull, PULL_RESET);
    chk("tw_rst2", tw_sel, TW_SEL_RESET);
    chk("test_rst2", ten, 1'b0);
  endtask
  initial
  begin
    #200000;
    err_count++;
    final_report;
  end
  initial
  begin
    step(7);
    mid;
    chk("rc_in_reset", {pad.oe[LINE_RC_OUT], pad.out[LINE_RC_OUT]}, {1'b1, osc});
    chk("tck_pull_rst", pad.pull[LINE_TCK], 1'b1);
    step(1);
    rst <= 1'b0;
    por <= 1'b0;
    step(2);
    mid;
    chk("pull_reset", pad.pull, PULL_RESET);
    chk("oe_reset", pad.oe & ~(36'h1 << LINE_RC_OUT), 36'h0);
    chk("tw_reset", tw_sel, TW_SEL_RESET);
    chk("rc_default", pad.oe[LINE_RC_OUT], 1'b1);
    t_test_port;
    t_lines;
    t_rc;
    final_report;
  end
endmodule
